// ===== cmp_logic.sv
// Digital side of one analog comparator: polarity, sync, edges, routing.
// Assumes the analog result and timer clock arrive as pins; software bits
// are plain ports on MCLK.
`timescale 1ns/1ps
`default_nettype none
module cmp_logic
(
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic ANALOG_GT,
   input wire logic GATE_CLK,
   input wire logic COMPARATOR_ON,
   input wire logic OUTPUT_INVERT,
   input wire logic SPEED_SELECT_WR,
   input wire logic SPEED_SELECT_DATA,
   input wire logic HYSTERESIS_ENABLE,
   input wire logic SYNC_TO_GATE_TIMER,
   input wire logic RESULT_PIN_ENABLE,
   input wire logic PIN_DIRECTION,
   input wire logic PORT_LATCH,
   input wire logic ANALOG_SELECT,
   input wire logic PIN_LEVEL,
   input wire logic RISE_IRQ_ENABLE,
   input wire logic FALL_IRQ_ENABLE,
   input wire logic IRQ_FLAG_CLEAR,
   input wire logic [cmp_pkg::SEL_W-1:0] POSITIVE_INPUT_SELECT,
   input wire logic [cmp_pkg::SEL_W-1:0] NEGATIVE_INPUT_SELECT,
   output logic COMPARE_RESULT,
   output logic COMPARE_IRQ_FLAG,
   output logic SPEED_SELECT,
   output logic HYSTERESIS_ON,
   output logic [3:0] POSITIVE_ROUTE,
   output logic [3:0] NEGATIVE_ROUTE,
   output logic GATE_SOURCE,
   output logic GATE_TIMER_TICK,
   output logic SHUTDOWN_SOURCE,
   output logic RESULT_PIN_OUT,
   output logic RESULT_PIN_OE,
   output logic PORT_READ
);
   import cmp_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // One-hot route word; a comparator that is off connects nothing
   function automatic logic [3:0] one_hot(input logic [SEL_W-1:0] sel, input logic on);
      if (on)
         one_hot = 4'h1 << sel;
      else
         one_hot = 4'h0;
   endfunction : one_hot

   // Edge of a level against its value one clock earlier
   function automatic logic edge_seen(input logic level, input logic last, input logic up);
      if (up)
         edge_seen = level & ~last;
      else
         edge_seen = ~level & last;
   endfunction : edge_seen

   logic cmp_s;
   logic gclk_s;
   logic gclk_d;
   logic pin_s;
   logic gate_fall;
   logic gate_rise;
   logic raw;
   logic synced;
   logic next_result;
   logic result_prev;
   logic rise_ev;
   logic fall_ev;
   logic set_flag;
   logic next_flag;
   logic next_speed;
   logic next_pin_out;
   logic next_pin_oe;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Three flops plus agreement cost about four clocks on every pin
   cmp_sync u_cmp_sync
   (
      .clk(MCLK),
      .arst_n(ARST_N),
      .din(ANALOG_GT),
      .dout(cmp_s)
   );

   // GATE_CLK is the timer clock after its prescaler
   cmp_sync u_gate_sync
   (
      .clk(MCLK),
      .arst_n(ARST_N),
      .din(GATE_CLK),
      .dout(gclk_s)
   );

   // Readback pin is outside the clock domain too, so it gets the same chain
   cmp_sync u_pin_sync
   (
      .clk(MCLK),
      .arst_n(ARST_N),
      .din(PIN_LEVEL),
      .dout(pin_s)
   );

   // ----------------------------------------
   // Gate clock edges
   // ----------------------------------------
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         gclk_d <= 1'h0;
      else
         gclk_d <= gclk_s;
   end

   assign gate_fall = edge_seen(gclk_s, gclk_d, 1'h0);
   assign gate_rise = edge_seen(gclk_s, gclk_d, 1'h1);

   // ----------------------------------------
   // Polarity
   // ----------------------------------------
   // Off comparator gives a low raw level, inverted as usual, so toggling
   // the invert bit alone still moves the result
   assign raw = (COMPARATOR_ON & cmp_s) ^ OUTPUT_INVERT;

   // ----------------------------------------
   // Timer synchronisation
   // ----------------------------------------
   // A level that changes between captures shows only at the next falling
   // edge; that delay is the price of a gate free of races
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         synced <= RESULT_RESET;
      else if (gate_fall)
         synced <= raw;
   end

   // ----------------------------------------
   // Result register
   // ----------------------------------------
   always_comb
   begin
      if (SYNC_TO_GATE_TIMER)
         next_result = synced;
      else
         next_result = raw;
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         COMPARE_RESULT <= RESULT_RESET;
      else
         COMPARE_RESULT <= next_result;
   end

   // ----------------------------------------
   // Gate timer tick
   // ----------------------------------------
   // Tick on rising edge so it never lands with the falling-edge capture
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         GATE_TIMER_TICK <= 1'h0;
      else
         GATE_TIMER_TICK <= gate_rise;
   end

   // ----------------------------------------
   // Edge detectors
   // ----------------------------------------
   // Both detectors watch the registered result, so a blip shorter than
   // one clock never reaches the flag
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         result_prev <= RESULT_RESET;
      else
         result_prev <= COMPARE_RESULT;
   end

   assign rise_ev = edge_seen(COMPARE_RESULT, result_prev, 1'h1) & RISE_IRQ_ENABLE;
   assign fall_ev = edge_seen(COMPARE_RESULT, result_prev, 1'h0) & FALL_IRQ_ENABLE;
   assign set_flag = rise_ev | fall_ev;

   // ----------------------------------------
   // Interrupt flag
   // ----------------------------------------
   // Set beats clear, so an edge that lands on the clear is never lost
   always_comb
   begin
      next_flag = COMPARE_IRQ_FLAG;
      if (IRQ_FLAG_CLEAR)
         next_flag = 1'h0;
      if (set_flag)
         next_flag = 1'h1;
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         COMPARE_IRQ_FLAG <= 1'h0;
      else
         COMPARE_IRQ_FLAG <= next_flag;
   end

   // ----------------------------------------
   // Speed and hysteresis
   // ----------------------------------------
   always_comb
   begin
      next_speed = SPEED_SELECT;
      if (SPEED_SELECT_WR)
         next_speed = SPEED_SELECT_DATA;
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         SPEED_SELECT <= SPEED_RESET;
      else
         SPEED_SELECT <= next_speed;
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         HYSTERESIS_ON <= 1'h0;
      else
         HYSTERESIS_ON <= HYSTERESIS_ENABLE;
   end

   // ----------------------------------------
   // Input routing
   // ----------------------------------------
   // Bit order: 0 pin, 1 DAC, 2 reference, 3 ground
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         POSITIVE_ROUTE <= 4'h0;
      else
         POSITIVE_ROUTE <= one_hot(POSITIVE_INPUT_SELECT, COMPARATOR_ON);
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         NEGATIVE_ROUTE <= 4'h0;
      else
         NEGATIVE_ROUTE <= one_hot(NEGATIVE_INPUT_SELECT, COMPARATOR_ON);
   end

   // ----------------------------------------
   // Timer gate and PWM shutdown
   // ----------------------------------------
   // Both consumers take the same registered result
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         GATE_SOURCE <= 1'h0;
      else
         GATE_SOURCE <= COMPARE_RESULT;
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         SHUTDOWN_SOURCE <= 1'h0;
      else
         SHUTDOWN_SOURCE <= COMPARE_RESULT;
   end

   // ----------------------------------------
   // Result pin
   // ----------------------------------------
   // Output enable overrides the port latch on the pin
   always_comb
   begin
      next_pin_out = PORT_LATCH;
      next_pin_oe = ~PIN_DIRECTION;
      if (RESULT_PIN_ENABLE)
      begin
         next_pin_out = COMPARE_RESULT;
         next_pin_oe = ~PIN_DIRECTION & COMPARATOR_ON;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         RESULT_PIN_OUT <= 1'h0;
      else
         RESULT_PIN_OUT <= next_pin_out;
   end

   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         RESULT_PIN_OE <= 1'h0;
      else
         RESULT_PIN_OE <= next_pin_oe;
   end

   // ----------------------------------------
   // Port readback
   // ----------------------------------------
   // An analog pin reads zero; a digital one lags by the chain's latency plus one register
   always_ff @(posedge MCLK or negedge ARST_N)
   begin
      if (!ARST_N)
         PORT_READ <= 1'h0;
      else
         PORT_READ <= ~ANALOG_SELECT & pin_s;
   end
endmodule : cmp_logic
`default_nettype wire

// ===== cmp_logic_asserts.sv
// Concurrent checks on the comparator output logic ports.
// Assumes one MCLK domain and ARST_N active low.
`timescale 1ns/1ps
`default_nettype none
module cmp_logic_chk
(
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic COMPARATOR_ON,
   input wire logic SPEED_SELECT_WR,
   input wire logic SPEED_SELECT_DATA,
   input wire logic HYSTERESIS_ENABLE,
   input wire logic RESULT_PIN_ENABLE,
   input wire logic PIN_DIRECTION,
   input wire logic PORT_LATCH,
   input wire logic PIN_LEVEL,
   input wire logic GATE_CLK,
   input wire logic ANALOG_SELECT,
   input wire logic RISE_IRQ_ENABLE,
   input wire logic FALL_IRQ_ENABLE,
   input wire logic IRQ_FLAG_CLEAR,
   input wire logic [cmp_pkg::SEL_W-1:0] POSITIVE_INPUT_SELECT,
   input wire logic [cmp_pkg::SEL_W-1:0] NEGATIVE_INPUT_SELECT,
   input wire logic COMPARE_RESULT,
   input wire logic COMPARE_IRQ_FLAG,
   input wire logic SPEED_SELECT,
   input wire logic HYSTERESIS_ON,
   input wire logic [3:0] POSITIVE_ROUTE,
   input wire logic [3:0] NEGATIVE_ROUTE,
   input wire logic GATE_SOURCE,
   input wire logic GATE_TIMER_TICK,
   input wire logic SHUTDOWN_SOURCE,
   input wire logic RESULT_PIN_OUT,
   input wire logic RESULT_PIN_OE,
   input wire logic PORT_READ
);
   import cmp_pkg::*;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   a_speed_load: assert property (SPEED_SELECT_WR |=>
      SPEED_SELECT == $past(SPEED_SELECT_DATA)) else $error("speed load");
   a_hyst_follow: assert property (1 |=>
      HYSTERESIS_ON == $past(HYSTERESIS_ENABLE)) else $error("hysteresis");
   a_input_routes: assert property (1 |=> {POSITIVE_ROUTE, NEGATIVE_ROUTE} ==
      ($past(COMPARATOR_ON) ? {4'h1 << $past(POSITIVE_INPUT_SELECT),
      4'h1 << $past(NEGATIVE_INPUT_SELECT)} : 8'h00)) else $error("routes");
   a_rise_flag: assert property ($rose(COMPARE_RESULT) && RISE_IRQ_ENABLE &&
      $past(RISE_IRQ_ENABLE) |=> COMPARE_IRQ_FLAG) else $error("rise flag");
   a_fall_flag: assert property ($fell(COMPARE_RESULT) && FALL_IRQ_ENABLE &&
      $past(FALL_IRQ_ENABLE) |=> COMPARE_IRQ_FLAG) else $error("fall flag");
   a_flag_no_selfclear: assert property ($fell(COMPARE_IRQ_FLAG) |->
      $past(IRQ_FLAG_CLEAR)) else $error("flag cleared alone");
   a_pin_drive: assert property (1 |=> RESULT_PIN_OE == (!$past(PIN_DIRECTION) &&
      (!$past(RESULT_PIN_ENABLE) || $past(COMPARATOR_ON)))) else $error("pin oe");
   a_analog_read: assert property (ANALOG_SELECT |=> !PORT_READ)
      else $error("analog readback");
   a_pin_readback: assert property (!ANALOG_SELECT &&
      $past(PIN_LEVEL, 3) == $past(PIN_LEVEL, 4) |=> PORT_READ == $past(PIN_LEVEL, 5))
      else $error("pin readback");
   a_gate_follow: assert property (1 |=> GATE_SOURCE == $past(COMPARE_RESULT))
      else $error("gate source");
   a_shutdown_follow: assert property (1 |=> SHUTDOWN_SOURCE == $past(COMPARE_RESULT))
      else $error("shutdown source");
   a_pin_value: assert property (1 |=> RESULT_PIN_OUT == ($past(RESULT_PIN_ENABLE) ?
      $past(COMPARE_RESULT) : $past(PORT_LATCH))) else $error("pin value");
   a_tick_rise: assert property (GATE_TIMER_TICK |->
      $past(GATE_CLK, 4) && $past(GATE_CLK, 5)) else $error("timer tick");
endmodule : cmp_logic_chk
bind cmp_logic cmp_logic_chk u_chk
(
   .MCLK(MCLK),
   .ARST_N(ARST_N),
   .COMPARATOR_ON(COMPARATOR_ON),
   .SPEED_SELECT_WR(SPEED_SELECT_WR),
   .SPEED_SELECT_DATA(SPEED_SELECT_DATA),
   .HYSTERESIS_ENABLE(HYSTERESIS_ENABLE),
   .RESULT_PIN_ENABLE(RESULT_PIN_ENABLE),
   .PIN_DIRECTION(PIN_DIRECTION),
   .PORT_LATCH(PORT_LATCH),
   .PIN_LEVEL(PIN_LEVEL),
   .GATE_CLK(GATE_CLK),
   .ANALOG_SELECT(ANALOG_SELECT),
   .RISE_IRQ_ENABLE(RISE_IRQ_ENABLE),
   .FALL_IRQ_ENABLE(FALL_IRQ_ENABLE),
   .IRQ_FLAG_CLEAR(IRQ_FLAG_CLEAR),
   .POSITIVE_INPUT_SELECT(POSITIVE_INPUT_SELECT),
   .NEGATIVE_INPUT_SELECT(NEGATIVE_INPUT_SELECT),
   .COMPARE_RESULT(COMPARE_RESULT),
   .COMPARE_IRQ_FLAG(COMPARE_IRQ_FLAG),
   .SPEED_SELECT(SPEED_SELECT),
   .HYSTERESIS_ON(HYSTERESIS_ON),
   .POSITIVE_ROUTE(POSITIVE_ROUTE),
   .NEGATIVE_ROUTE(NEGATIVE_ROUTE),
   .GATE_SOURCE(GATE_SOURCE),
   .GATE_TIMER_TICK(GATE_TIMER_TICK),
   .SHUTDOWN_SOURCE(SHUTDOWN_SOURCE),
   .RESULT_PIN_OUT(RESULT_PIN_OUT),
   .RESULT_PIN_OE(RESULT_PIN_OE),
   .PORT_READ(PORT_READ)
);
`default_nettype wire

// ===== cmp_pkg.sv
// Constants for the comparator output logic.
// Assumes a single 100 MHz instruction clock domain.
package cmp_pkg;
   // ----------------------------------------
   // Input selects
   // ----------------------------------------
   localparam logic [1:0] PSEL_PIN = 2'h0;
   localparam logic [1:0] PSEL_DAC = 2'h1;
   localparam logic [1:0] PSEL_FVR = 2'h2;
   localparam logic [1:0] PSEL_GND = 2'h3;
   localparam int SEL_W = 2;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic SPEED_RESET = 1'h1;
   localparam logic RESULT_RESET = 1'h0;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int SYNC_STAGES = 3;
endpackage : cmp_pkg

// ===== cmp_sync.sv
// Three-stage synchroniser with agreement filter for an outside level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module cmp_sync
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic din,
   output logic dout
);
   logic s1;
   logic s2;
   logic s3;
   // ----------------------------------------
   // Chain
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1 <= 1'h0;
         s2 <= 1'h0;
         s3 <= 1'h0;
      end
      else
      begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // A change counts only once stages two and three agree
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         dout <= 1'h0;
      else if (s2 == s3)
         dout <= s3;
   end
endmodule : cmp_sync
`default_nettype wire

// ===== tb_cmp_logic.sv
// Self-checking bench for cmp_logic, with its checker bound in.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_cmp_logic;
   import cmp_pkg::*;
   logic MCLK, ARST_N, ANALOG_GT, GATE_CLK, COMPARATOR_ON, OUTPUT_INVERT;
   logic SPEED_SELECT_WR, SPEED_SELECT_DATA, HYSTERESIS_ENABLE, SYNC_TO_GATE_TIMER;
   logic RESULT_PIN_ENABLE, PIN_DIRECTION, PORT_LATCH, ANALOG_SELECT, PIN_LEVEL;
   logic RISE_IRQ_ENABLE, FALL_IRQ_ENABLE, IRQ_FLAG_CLEAR;
   logic [SEL_W-1:0] POSITIVE_INPUT_SELECT, NEGATIVE_INPUT_SELECT;
   logic COMPARE_RESULT, COMPARE_IRQ_FLAG, SPEED_SELECT, HYSTERESIS_ON, GATE_SOURCE;
   logic GATE_TIMER_TICK, SHUTDOWN_SOURCE, RESULT_PIN_OUT, RESULT_PIN_OE, PORT_READ;
   logic [3:0] POSITIVE_ROUTE, NEGATIVE_ROUTE;
   logic [2:0] notes[$];
   logic [2:0] exp_v;
   logic [31:0] r;
   int error_cnt = 0, checks = 0, i;
   cmp_logic DUT
   (
      .MCLK(MCLK),
      .ARST_N(ARST_N),
      .ANALOG_GT(ANALOG_GT),
      .GATE_CLK(GATE_CLK),
      .COMPARATOR_ON(COMPARATOR_ON),
      .OUTPUT_INVERT(OUTPUT_INVERT),
      .SPEED_SELECT_WR(SPEED_SELECT_WR),
      .SPEED_SELECT_DATA(SPEED_SELECT_DATA),
      .HYSTERESIS_ENABLE(HYSTERESIS_ENABLE),
      .SYNC_TO_GATE_TIMER(SYNC_TO_GATE_TIMER),
      .RESULT_PIN_ENABLE(RESULT_PIN_ENABLE),
      .PIN_DIRECTION(PIN_DIRECTION),
      .PORT_LATCH(PORT_LATCH),
      .ANALOG_SELECT(ANALOG_SELECT),
      .PIN_LEVEL(PIN_LEVEL),
      .RISE_IRQ_ENABLE(RISE_IRQ_ENABLE),
      .FALL_IRQ_ENABLE(FALL_IRQ_ENABLE),
      .IRQ_FLAG_CLEAR(IRQ_FLAG_CLEAR),
      .POSITIVE_INPUT_SELECT(POSITIVE_INPUT_SELECT),
      .NEGATIVE_INPUT_SELECT(NEGATIVE_INPUT_SELECT),
      .COMPARE_RESULT(COMPARE_RESULT),
      .COMPARE_IRQ_FLAG(COMPARE_IRQ_FLAG),
      .SPEED_SELECT(SPEED_SELECT),
      .HYSTERESIS_ON(HYSTERESIS_ON),
      .POSITIVE_ROUTE(POSITIVE_ROUTE),
      .NEGATIVE_ROUTE(NEGATIVE_ROUTE),
      .GATE_SOURCE(GATE_SOURCE),
      .GATE_TIMER_TICK(GATE_TIMER_TICK),
      .SHUTDOWN_SOURCE(SHUTDOWN_SOURCE),
      .RESULT_PIN_OUT(RESULT_PIN_OUT),
      .RESULT_PIN_OE(RESULT_PIN_OE),
      .PORT_READ(PORT_READ)
   );
   initial
   begin
      MCLK = 1'h0;
      forever #5 MCLK = ~MCLK;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask : cyc
   task automatic conclude;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // ----------------------------------------
   // Monitor: oldest note against {result, flag, speed}
   // ----------------------------------------
   always @(negedge MCLK)
   begin
      if (notes.size() > 0)
      begin
         exp_v = notes.pop_front();
         checks++;
         if ({COMPARE_RESULT, COMPARE_IRQ_FLAG, SPEED_SELECT} !== exp_v)
         begin
            error_cnt++;
            $display("CHECK FAILED result_flag_speed exp %b got %b", exp_v,
               {COMPARE_RESULT, COMPARE_IRQ_FLAG, SPEED_SELECT});
         end
      end
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      {ARST_N, ANALOG_GT, COMPARATOR_ON, OUTPUT_INVERT, SPEED_SELECT_WR, SPEED_SELECT_DATA,
         HYSTERESIS_ENABLE, SYNC_TO_GATE_TIMER, RESULT_PIN_ENABLE, PORT_LATCH, ANALOG_SELECT,
         PIN_LEVEL, RISE_IRQ_ENABLE, FALL_IRQ_ENABLE, IRQ_FLAG_CLEAR, POSITIVE_INPUT_SELECT,
         NEGATIVE_INPUT_SELECT} = '0;
      PIN_DIRECTION = 1'h1;
      GATE_CLK = 1'h1;
      r = $urandom(34642);
      cyc(6);
      ARST_N = 1'h1;
      cyc(1);
      notes.push_back(3'h1);
      // Comparator off: polarity flip alone must raise an edge
      RISE_IRQ_ENABLE = 1'h1;
      OUTPUT_INVERT = 1'h1;
      cyc(3);
      notes.push_back(3'h7);
      cyc(6);
      notes.push_back(3'h7);
      IRQ_FLAG_CLEAR = 1'h1;
      cyc(1);
      {IRQ_FLAG_CLEAR, RISE_IRQ_ENABLE, FALL_IRQ_ENABLE} = 3'h1;
      cyc(2);
      notes.push_back(3'h5);
      OUTPUT_INVERT = 1'h0;
      cyc(3);
      notes.push_back(3'h3);
      {IRQ_FLAG_CLEAR, FALL_IRQ_ENABLE, COMPARATOR_ON} = 3'h5;
      cyc(1);
      IRQ_FLAG_CLEAR = 1'h0;
      for (i = 0; i < 4; i++)
      begin
         {ANALOG_GT, OUTPUT_INVERT} = i[1:0];
         cyc(10);
         notes.push_back({i[1] ^ i[0], 2'h1});
      end
      // Sync mode: new level held back until gate clock falls
      {ANALOG_GT, OUTPUT_INVERT} = 2'h0;
      cyc(10);
      SYNC_TO_GATE_TIMER = 1'h1;
      cyc(8);
      ANALOG_GT = 1'h1;
      cyc(10);
      notes.push_back(3'h1);
      GATE_CLK = 1'h0;
      cyc(10);
      notes.push_back(3'h5);
      {GATE_CLK, SYNC_TO_GATE_TIMER, SPEED_SELECT_WR} = 3'h5;
      cyc(1);
      SPEED_SELECT_WR = 1'h0;
      cyc(1);
      notes.push_back(3'h4);
      for (i = 0; i < 300; i++)
      begin
         r = $urandom();
         {OUTPUT_INVERT, COMPARATOR_ON, HYSTERESIS_ENABLE, RESULT_PIN_ENABLE, PIN_DIRECTION,
            PORT_LATCH, ANALOG_SELECT, PIN_LEVEL, RISE_IRQ_ENABLE, FALL_IRQ_ENABLE,
            POSITIVE_INPUT_SELECT, NEGATIVE_INPUT_SELECT, SPEED_SELECT_WR,
            SPEED_SELECT_DATA, IRQ_FLAG_CLEAR} = r[16:0];
         {ANALOG_GT, GATE_CLK, SYNC_TO_GATE_TIMER} = r[19:17];
         cyc(1);
      end
      cyc(2);
      conclude();
   end
   initial
   begin
      #20000;
      error_cnt++;
      conclude();
   end
endmodule : tb_cmp_logic
`default_nettype wire
